// *** design/sprc_regs.vh ***
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz system clock
`ifndef SPRC_REGS_VH
`define SPRC_REGS_VH
// register indices (printed offsets are not word multiples)
`define SPRC_IDX_CLOCK_GATE 8'h35
`define SPRC_IDX_SLEEP_CTRL 8'h3a
// registers of our own, indices
`define SPRC_IDX_SUPPLY_MON 8'h40
`define SPRC_IDX_RESET_FLAGS 8'h41
`define SPRC_IDX_INPUT_DIS 8'h42
`define SPRC_IDX_SLEEP_CMD 8'h43
`define SPRC_IDX_STATUS 8'h44
// sleep_control fields
`define SPRC_SE_BIT 0
`define SPRC_SM_LSB 1
`define SPRC_SM_MSB 3
`define SPRC_SM_IDLE 3'h0
`define SPRC_SM_ADC_NR 3'h1
`define SPRC_SM_PDOWN 3'h2
`define SPRC_SM_STANDBY 3'h4
// peripheral_clock_gate fields
`define SPRC_PR_TIM0_BIT 0
`define SPRC_PR_ADC_BIT 1
`define SPRC_PR_USART_BIT 2
`define SPRC_PR_MASK 8'h07
// supply_monitor_control fields
`define SPRC_VLM_LVL_LSB 0
`define SPRC_VLM_LVL_MSB 2
`define SPRC_VLM_IE_BIT 3
`define SPRC_VLM_RST_BIT 4
`define SPRC_VLM_FLAG_BIT 5
// reset flag positions
`define SPRC_POWERON_RESET_FLAG_BIT 0
`define SPRC_EXTRF_BIT 1
`define SPRC_VLMRF_BIT 2
`define SPRC_WDRF_BIT 3
// reset values
`define SPRC_RST_BYTE 8'h00
// timing
`define SPRC_CLK_MHZ 50
`define SPRC_TOUT_US 64
`define SPRC_TOUT_CYC (`SPRC_TOUT_US * `SPRC_CLK_MHZ)
`define SPRC_EXT_MIN_NS 2500
`define SPRC_EXT_MIN_CYC ((`SPRC_EXT_MIN_NS + 19) / 20)
`define SPRC_WAKE_EXTRA 4
`endif

// *** design/sprc_reset_stretch.v ***
// reset merger and start-up time-out stretcher
// assumes raw sources already synchronised except the async ones
`timescale 1ns/1ps
`include "sprc_regs.vh"
module sprc_reset_stretch #(
  parameter TOUT_CYC = `SPRC_TOUT_CYC
) (
  input wire clk,
  input wire any_src,
  output wire io_reset,
  output reg core_reset_reg
);
  // ----------------------------------------------------------------
  // asynchronous capture of any source
  // ----------------------------------------------------------------
  reg [15:0] cnt_reg;
  reg held_reg;
  // ports drop to reset without a clock, straight from the source
  assign io_reset = any_src;
  always @(posedge clk or posedge any_src) begin
    if (any_src) begin
      held_reg <= 1'b1;
      cnt_reg <= 16'h0000;
      core_reset_reg <= 1'b1;
    end else if (held_reg) begin
      // count starts once every source is gone, incl. wdt pulse fall
      if (cnt_reg == TOUT_CYC[15:0] - 16'h0001) begin
        held_reg <= 1'b0;
        core_reset_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule // sprc_reset_stretch

// *** design/sprc_power_ctrl.v ***
// sleep, clock gating and reset controller, axi4-lite slave
// assumes the core pulses sleep_instr and reports wake sources
// Operation
// - mode field picks idle, noise, down, standby
// - sleep only when enable bit set
// - gate bit two stops serial clock
// - gate bit one kills converter, comparator mux
// - gate bit zero freezes timer zero
// - power-down disables analog comparator
// - comparator on reference keeps reference up
// - enabled converter stays on while sleeping
// - reference powered only when someone needs it
// - watchdog never stopped by sleep
// - io clock off disables input buffers except wake pins
// - input disable register forces buffers off
// - reset loads registers, core restarts vector
// - ports reset immediately without clock
// - time-out stretches reset after sources
// - power-on reset reasserts without delay
// - supply low flag set and clears
// - supply monitor reset holds then starts
// - power-on flag set after recovery
// - long reset pin low resets, fuse disables
// - watchdog pulse one cycle, count on fall
// - wake halts core four cycles extra
// - gated peripheral frozen, registers locked
// - per-mode clock stopping
`timescale 1ns/1ps
`include "sprc_regs.vh"
module sprc_power_ctrl #(
  parameter TOUT_CYC = `SPRC_TOUT_CYC,
  parameter NPIN = 8
) (
  input wire clk,
  input wire rst,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire sleep_instr,
  input wire wake_irq,
  input wire wdt_enabled,
  input wire wdt_reset_pulse,
  input wire por_raw,
  input wire supply_below,
  input wire reset_pin_n,
  input wire ext_reset_disable_fuse,
  input wire comp_enabled,
  input wire comp_uses_ref,
  input wire conv_enabled,
  output reg cpu_clk_en_reg,
  output reg nvm_clk_en_reg,
  output reg io_clk_en_reg,
  output reg adc_clk_en_reg,
  output reg osc_en_reg,
  output reg serial_clk_en_reg,
  output reg conv_clk_en_reg,
  output reg timer0_clk_en_reg,
  output reg comp_mux_allow_reg,
  output reg comp_force_off_reg,
  output reg ref_power_reg,
  output reg conv_extended_reg,
  output reg wdt_run_reg,
  output reg [NPIN-1:0] input_buf_en_reg,
  output reg core_halt_reg,
  output reg core_reset_reg,
  output reg io_reset_reg
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_RUN = 3'b001;
  localparam ST_SLEEP = 3'b010;
  localparam ST_WAKE = 3'b100;
  reg [2:0] state_reg;
  reg [2:0] mode_reg;
  reg [2:0] wake_cnt_reg;
  reg [7:0] gate_reg;
  reg [3:0] sleep_ctl_reg;
  reg [4:0] vlm_ctl_reg;
  reg vlm_flag_reg;
  reg [3:0] rst_flags_reg;
  reg [NPIN-1:0] in_dis_reg;
  reg [NPIN-1:0] wake_pins_reg;
  reg conv_prev_reg;
  reg [2:0] pin_sync_reg;
  reg [2:0] sup_sync_reg;
  reg [7:0] ext_cnt_reg;
  reg ext_rst_reg;
  reg vlm_rst_reg;
  reg por_seen_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [31:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire any_src;
  wire io_rst_w;
  wire core_rst_w;
  wire sup_low;
  wire pin_low;
  wire [2:0] sel_mode;
  wire do_write;

  // byte address to register index, invalid if not word aligned
  function [8:0] idx_of;
    input [31:0] a;
    begin
      idx_of = (a[1:0] == 2'b00 && a[31:10] == 22'h0) ?
        {1'b1, a[9:2]} : 9'h000;
    end
  endfunction

  function known_mode;
    input [2:0] m;
    begin
      known_mode = (m == `SPRC_SM_IDLE) || (m == `SPRC_SM_ADC_NR) ||
        (m == `SPRC_SM_PDOWN) || (m == `SPRC_SM_STANDBY);
    end
  endfunction

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // external pin and supply level: three flops, asserted only while 2 and 3 agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_sync_reg <= 3'h7;
      sup_sync_reg <= 3'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], reset_pin_n};
      sup_sync_reg <= {sup_sync_reg[1:0], supply_below};
    end
  end
  assign pin_low = ~pin_sync_reg[1] & ~pin_sync_reg[2];
  assign sup_low = sup_sync_reg[1] & sup_sync_reg[2];

  // pin must stay low the minimum width; the fuse blocks it entirely
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_cnt_reg <= 8'h00;
      ext_rst_reg <= 1'b0;
      vlm_rst_reg <= 1'b0;
    end else begin
      vlm_rst_reg <= sup_low & vlm_ctl_reg[`SPRC_VLM_RST_BIT];
      if (!pin_low || ext_reset_disable_fuse) begin
        ext_cnt_reg <= 8'h00;
        ext_rst_reg <= 1'b0;
      end else if (ext_cnt_reg == `SPRC_EXT_MIN_CYC - 1) begin
        ext_rst_reg <= 1'b1;
      end else begin
        ext_cnt_reg <= ext_cnt_reg + 8'h01;
      end
    end
  end

  // por and the watchdog pulse arrive without synchronising
  assign any_src = rst | por_raw | ext_rst_reg | vlm_rst_reg |
    wdt_reset_pulse;

  sprc_reset_stretch #(
    .TOUT_CYC(TOUT_CYC)
  ) u_stretch (
    .clk(clk),
    .any_src(any_src),
    .io_reset(io_rst_w),
    .core_reset_reg(core_rst_w)
  );

  // ----------------------------------------------------------------
  // axi4-lite write
  // ----------------------------------------------------------------
  assign do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign sel_mode = sleep_ctl_reg[`SPRC_SM_MSB:`SPRC_SM_LSB];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_hold_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_hold_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= idx_of(awaddr_reg) == 9'h000 ? 2'b10 : 2'b00;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register file; every io register takes its initial value in reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_reg <= `SPRC_RST_BYTE;
      sleep_ctl_reg <= 4'h0;
      vlm_ctl_reg <= 5'h00;
      vlm_flag_reg <= 1'b0;
      in_dis_reg <= {NPIN{1'b0}};
      wake_pins_reg <= {NPIN{1'b0}};
    end else begin
      // flag: set beats a software clear in the same cycle
      if (sup_low) begin
        vlm_flag_reg <= 1'b1;
      end else if (do_write && wstrb_reg[0] &&
          idx_of(awaddr_reg) == {1'b1, `SPRC_IDX_SUPPLY_MON} &&
          (!wdata_reg[`SPRC_VLM_FLAG_BIT] ||
           wdata_reg[2:0] != vlm_ctl_reg[2:0])) begin
        vlm_flag_reg <= 1'b0;
      end else if (sup_sync_reg[1] == 1'b0 && sup_sync_reg[2] == 1'b0) begin
        vlm_flag_reg <= 1'b0;
      end
      if (do_write && wstrb_reg[0]) begin
        case (idx_of(awaddr_reg))
          {1'b1, `SPRC_IDX_CLOCK_GATE}: begin
            gate_reg <= wdata_reg[7:0] & `SPRC_PR_MASK;
          end
          {1'b1, `SPRC_IDX_SLEEP_CTRL}: begin
            sleep_ctl_reg <= wdata_reg[3:0];
          end
          {1'b1, `SPRC_IDX_SUPPLY_MON}: begin
            vlm_ctl_reg <= wdata_reg[4:0];
          end
          {1'b1, `SPRC_IDX_INPUT_DIS}: begin
            in_dis_reg <= wdata_reg[NPIN-1:0];
          end
          {1'b1, `SPRC_IDX_SLEEP_CMD}: begin
            wake_pins_reg <= wdata_reg[NPIN-1:0];
          end
          default: begin
          end
        endcase
      end
      // every reset source, not only rst, restores the io registers except supply monitor control, its flag and the reset flags
      if (core_rst_w) begin
        gate_reg <= `SPRC_RST_BYTE;
        sleep_ctl_reg <= 4'h0;
        in_dis_reg <= {NPIN{1'b0}};
        wake_pins_reg <= {NPIN{1'b0}};
      end
    end
  end

  // reset cause flags; por flag appears once the supply has come back
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_flags_reg <= 4'h0;
      por_seen_reg <= 1'b0;
    end else begin
      if (por_raw) begin
        por_seen_reg <= 1'b1;
      end else if (por_seen_reg) begin
        por_seen_reg <= 1'b0;
        rst_flags_reg[`SPRC_POWERON_RESET_FLAG_BIT] <= 1'b1;
      end else if (do_write && wstrb_reg[0] &&
          idx_of(awaddr_reg) == {1'b1, `SPRC_IDX_RESET_FLAGS}) begin
        rst_flags_reg[`SPRC_POWERON_RESET_FLAG_BIT] <= wdata_reg[`SPRC_POWERON_RESET_FLAG_BIT];
      end
      if (ext_rst_reg) begin
        rst_flags_reg[`SPRC_EXTRF_BIT] <= 1'b1;
      end
      if (vlm_rst_reg) begin
        rst_flags_reg[`SPRC_VLMRF_BIT] <= 1'b1;
      end
      if (wdt_reset_pulse) begin
        rst_flags_reg[`SPRC_WDRF_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      case (idx_of(s_axi_araddr))
        {1'b1, `SPRC_IDX_CLOCK_GATE}: s_axi_rdata[7:0] <= gate_reg;
        {1'b1, `SPRC_IDX_SLEEP_CTRL}: s_axi_rdata[3:0] <= sleep_ctl_reg;
        {1'b1, `SPRC_IDX_SUPPLY_MON}:
          s_axi_rdata[5:0] <= {vlm_flag_reg, vlm_ctl_reg};
        {1'b1, `SPRC_IDX_RESET_FLAGS}: s_axi_rdata[3:0] <= rst_flags_reg;
        {1'b1, `SPRC_IDX_INPUT_DIS}: s_axi_rdata[NPIN-1:0] <= in_dis_reg;
        {1'b1, `SPRC_IDX_SLEEP_CMD}: s_axi_rdata[NPIN-1:0] <= wake_pins_reg;
        {1'b1, `SPRC_IDX_STATUS}: s_axi_rdata[5:0] <= {state_reg, mode_reg};
        default: s_axi_rresp <= 2'b10;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sleep sequencer
  // ----------------------------------------------------------------
  // software is expected to set enable right before sleep, side
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_RUN;
      mode_reg <= `SPRC_SM_IDLE;
      wake_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_RUN: begin
          // reserved pattern: sleep falls through to the next instruction
          if (sleep_instr && sleep_ctl_reg[`SPRC_SE_BIT] &&
              known_mode(sel_mode)) begin
            state_reg <= ST_SLEEP;
            mode_reg <= sel_mode;
          end
        end
        ST_SLEEP: begin
          if (wake_irq) begin
            state_reg <= ST_WAKE;
            wake_cnt_reg <= 3'h0;
          end
        end
        ST_WAKE: begin
          if (wake_cnt_reg == `SPRC_WAKE_EXTRA - 1) begin
            state_reg <= ST_RUN;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 3'h1;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // clock, analog and pin controls
  // ----------------------------------------------------------------
  wire asleep = (state_reg != ST_RUN);
  wire deep = (state_reg == ST_SLEEP) && (mode_reg == `SPRC_SM_PDOWN ||
    mode_reg == `SPRC_SM_STANDBY);
  wire io_stop = (state_reg == ST_SLEEP) && (mode_reg != `SPRC_SM_IDLE);
  wire pd = (state_reg == ST_SLEEP) && (mode_reg == `SPRC_SM_PDOWN);
  wire comp_live = comp_enabled & ~pd;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en_reg <= 1'b1;
      nvm_clk_en_reg <= 1'b1;
      io_clk_en_reg <= 1'b1;
      adc_clk_en_reg <= 1'b1;
      osc_en_reg <= 1'b1;
      serial_clk_en_reg <= 1'b1;
      conv_clk_en_reg <= 1'b1;
      timer0_clk_en_reg <= 1'b1;
      comp_mux_allow_reg <= 1'b1;
      comp_force_off_reg <= 1'b0;
      ref_power_reg <= 1'b0;
      conv_extended_reg <= 1'b1;
      conv_prev_reg <= 1'b0;
      wdt_run_reg <= 1'b0;
      input_buf_en_reg <= {NPIN{1'b0}};
      core_halt_reg <= 1'b0;
    end else begin
      cpu_clk_en_reg <= ~asleep;
      nvm_clk_en_reg <= ~asleep;
      io_clk_en_reg <= ~io_stop;
      adc_clk_en_reg <= ~deep;
      osc_en_reg <= ~pd;
      // gated peripherals hold state and lose register access
      serial_clk_en_reg <= ~gate_reg[`SPRC_PR_USART_BIT] & ~io_stop;
      conv_clk_en_reg <= ~gate_reg[`SPRC_PR_ADC_BIT] & ~deep;
      timer0_clk_en_reg <= ~gate_reg[`SPRC_PR_TIM0_BIT] & ~io_stop;
      comp_mux_allow_reg <= ~gate_reg[`SPRC_PR_ADC_BIT];
      comp_force_off_reg <= pd;
      ref_power_reg <= (comp_live & comp_uses_ref) | conv_enabled;
      // off-then-on of the converter makes the next conversion long
      conv_prev_reg <= conv_enabled;
      if (conv_enabled && !conv_prev_reg) begin
        conv_extended_reg <= 1'b1;
      end else if (!conv_enabled) begin
        conv_extended_reg <= 1'b0;
      end
      wdt_run_reg <= wdt_enabled;
      input_buf_en_reg <= ~in_dis_reg &
        (io_stop ? wake_pins_reg : {NPIN{1'b1}});
      core_halt_reg <= asleep;
    end
  end

  // reset outputs rise with a source at once, clock or not
  always @(posedge clk or posedge any_src) begin
    if (any_src) begin
      core_reset_reg <= 1'b1;
      io_reset_reg <= 1'b1;
    end else begin
      core_reset_reg <= core_rst_w;
      io_reset_reg <= io_rst_w;
    end
  end
endmodule // sprc_power_ctrl

// *** tb/sprc_power_checker.sv ***
// port assertions for the sleep, clock gate and reset controller
// assumes binding onto sprc_power_ctrl, one clock, rst async high
`timescale 1ns/1ps
module sprc_power_checker #(
  parameter TOUT_CYC = 8
) (
  input wire clk,
  input wire rst,
  input wire wake_irq,
  input wire wdt_enabled,
  input wire wdt_reset_pulse,
  input wire por_raw,
  input wire reset_pin_n,
  input wire ext_reset_disable_fuse,
  input wire comp_enabled,
  input wire comp_uses_ref,
  input wire conv_enabled,
  input wire cpu_clk_en_reg,
  input wire io_clk_en_reg,
  input wire adc_clk_en_reg,
  input wire osc_en_reg,
  input wire comp_force_off_reg,
  input wire ref_power_reg,
  input wire wdt_run_reg,
  input wire core_halt_reg,
  input wire core_reset_reg,
  input wire io_reset_reg
);
  // ------------
  // helper counts
  // ------------
  logic [15:0] tout_cnt;
  logic [7:0] pin_cnt;
  // stretch measured from the last cycle any source was active
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tout_cnt <= 16'h0000;
      pin_cnt <= 8'h00;
    end else begin
      if (io_reset_reg)
        tout_cnt <= 16'h0000;
      else if (core_reset_reg && tout_cnt != 16'hffff)
        tout_cnt <= tout_cnt + 16'h0001;
      if (!reset_pin_n && !ext_reset_disable_fuse && pin_cnt != 8'hff)
        pin_cnt <= pin_cnt + 8'h01;
      else if (reset_pin_n || ext_reset_disable_fuse)
        pin_cnt <= 8'h00;
    end
  end
  // ------------
  // assertions
  // ------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_halt_hold;
    core_halt_reg [*4];
  endsequence
  sequence s_resumed;
    !core_halt_reg;
  endsequence
  a_por_at_once: assert property (
    por_raw |-> ##[0:1] io_reset_reg && core_reset_reg)
    else $error("power-on source did not reset at once");
  a_tout_min: assert property (
    $fell(core_reset_reg) |-> tout_cnt >= TOUT_CYC)
    else $error("internal reset released too early");
  a_tout_max: assert property (
    core_reset_reg && !io_reset_reg |-> tout_cnt <= TOUT_CYC + 4)
    else $error("internal reset held too long");
  a_pin_reset: assert property (
    pin_cnt == 8'd140 |-> core_reset_reg)
    else $error("long pin low gave no reset");
  a_wdt_reset: assert property (
    wdt_reset_pulse |-> ##[0:2] core_reset_reg)
    else $error("watchdog pulse gave no reset");
  a_wdt_runs: assert property (
    wdt_enabled [*2] |-> wdt_run_reg)
    else $error("watchdog stopped while enabled");
  a_ref_needed: assert property (
    (comp_enabled && comp_uses_ref && !comp_force_off_reg
      && !core_reset_reg) [*2] |-> ref_power_reg)
    else $error("reference off while comparator uses it");
  a_ref_idle: assert property (
    (!(comp_enabled && comp_uses_ref) && !conv_enabled) [*2]
      |-> !ref_power_reg)
    else $error("reference on with no user");
  a_pdown_clocks: assert property (
    comp_force_off_reg |-> !(cpu_clk_en_reg || io_clk_en_reg
      || adc_clk_en_reg || osc_en_reg))
    else $error("clock running in power-down");
  a_wake_halt: assert property (
    $rose(wake_irq) && core_halt_reg && !core_reset_reg
      |-> s_halt_hold ##[1:4] s_resumed)
    else $error("wake halt length wrong");
endmodule // sprc_power_checker

// *** tb/sprc_core_model.sv ***
// stand-in for the core: sleep instruction pulse, wake level, analog users
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
module sprc_core_model (
  input wire clk,
  input wire core_halt_reg,
  output logic sleep_instr,
  output logic wake_irq,
  output logic comp_enabled,
  output logic comp_uses_ref,
  output logic conv_enabled
);
  initial begin
    sleep_instr = 1'b0;
    wake_irq = 1'b0;
    comp_enabled = 1'b0;
    comp_uses_ref = 1'b0;
    conv_enabled = 1'b0;
  end
  task automatic do_sleep();
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
  endtask
  // a level interrupt must stay up until the core is running again
  task automatic wake(input int dly, output int halt_cyc);
    repeat (dly) @(posedge clk);
    wake_irq <= 1'b1;
    halt_cyc = 0;
    do begin
      @(posedge clk);
      halt_cyc++;
    end while (core_halt_reg !== 1'b0 && halt_cyc < 50);
    wake_irq <= 1'b0;
  endtask
endmodule // sprc_core_model

// *** tb/sprc_power_ctrl_test.sv ***
// self-checking bench for the power, sleep and reset controller
// assumes sprc_regs.vh on the include path
`timescale 1ns/1ps
`include "sprc_regs.vh"
module sprc_power_ctrl_test;
  localparam TOUT = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, wdt_enabled = 1'b0;
  logic wdt_reset_pulse = 1'b0, por_raw = 1'b0, supply_below = 1'b0;
  logic reset_pin_n = 1'b1, ext_reset_disable_fuse = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sleep_instr, wake_irq, comp_enabled;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, v;
  logic comp_uses_ref, conv_enabled, cpu_clk_en_reg, nvm_clk_en_reg;
  logic io_clk_en_reg, adc_clk_en_reg, osc_en_reg, serial_clk_en_reg;
  logic conv_clk_en_reg, timer0_clk_en_reg, comp_mux_allow_reg;
  logic comp_force_off_reg, ref_power_reg, conv_extended_reg, ok;
  logic wdt_run_reg, core_halt_reg, core_reset_reg, io_reset_reg;
  logic [7:0] input_buf_en_reg;
  logic [1:0] wr_q[$];
  logic [33:0] rd_q[$];
  logic [33:0] rexp;
  int miscompares = 0, checks_done = 0, seed = 43550, hc;
  always #10 clk = ~clk;
  sprc_power_ctrl #(.TOUT_CYC(TOUT), .NPIN(8)) dut_u (.*);
  sprc_core_model core_u (.*);
  // ------------
  // checking
  // ------------
  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge clk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && wr_q.size() > 0)
      cmp("bresp", wr_q.pop_front(), s_axi_bresp);
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rd_q.size() > 0) begin
      rexp = rd_q.pop_front();
      cmp("rresp", rexp[33:32], s_axi_rresp);
      cmp("rdata", rexp[31:0], s_axi_rdata);
    end
  end
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0 && wr_q.size() == 0 &&
        rd_q.size() == 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
  // ------------
  // bus and reset helpers
  // ------------
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wr_q.push_back(2'b00);
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] idx, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rd_q.push_back({er, e});
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (core_reset_reg !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    cmp("core_reset", 0, core_reset_reg);
    repeat (2) @(posedge clk);
  endtask
  // ------------
  // scenarios
  // ------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_run();
    axi_rd(`SPRC_IDX_CLOCK_GATE, 32'h0, 2'b00);
    axi_rd(`SPRC_IDX_SLEEP_CTRL, 32'h0, 2'b00);
    axi_rd(8'h50, 32'h0, 2'b10);
    // converter parked before any gating, it must not be cut while busy
    core_u.conv_enabled <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      v = $random(seed) & 32'h7;
      axi_wr(`SPRC_IDX_CLOCK_GATE, v);
      axi_rd(`SPRC_IDX_CLOCK_GATE, v, 2'b00);
      cmp("serial_clk", !v[2], serial_clk_en_reg);
      cmp("conv_clk", !v[1], conv_clk_en_reg);
      cmp("comp_mux", !v[1], comp_mux_allow_reg);
      cmp("timer0_clk", !v[0], timer0_clk_en_reg);
    end
    axi_wr(`SPRC_IDX_CLOCK_GATE, 32'h0);
    core_u.conv_enabled <= 1'b1;
    repeat (3) @(posedge clk);
    cmp("ref_power", 1, ref_power_reg);
    core_u.conv_enabled <= 1'b0;
    repeat (3) @(posedge clk);
    core_u.conv_enabled <= 1'b1;
    repeat (3) @(posedge clk);
    cmp("conv_ext", 1, conv_extended_reg);
    core_u.comp_enabled <= 1'b1;
    core_u.comp_uses_ref <= 1'b1;
    axi_wr(`SPRC_IDX_INPUT_DIS, 32'hf);
    @(posedge clk);
    cmp("in_buf", 8'hf0, input_buf_en_reg);
    wdt_enabled <= 1'b1;
    axi_wr(`SPRC_IDX_SLEEP_CTRL, 32'h4);
    core_u.do_sleep();
    repeat (4) @(posedge clk);
    cmp("halt", 0, core_halt_reg);
    for (int m = 0; m < 8; m++) begin
      ok = (m < 3) || (m == 4);
      axi_wr(`SPRC_IDX_SLEEP_CTRL, {28'h0, m[2:0], 1'b1});
      core_u.do_sleep();
      repeat (4) @(posedge clk);
      cmp("halt", ok, core_halt_reg);
      if (ok) begin
        cmp("cpu_clk", 0, cpu_clk_en_reg);
        cmp("nvm_clk", 0, nvm_clk_en_reg);
        cmp("io_clk", m == 0, io_clk_en_reg);
        cmp("adc_clk", m < 2, adc_clk_en_reg);
        cmp("osc", m != 2, osc_en_reg);
        cmp("comp_off", m == 2, comp_force_off_reg);
        cmp("wdt_run", 1, wdt_run_reg);
        cmp("in_buf", m ? 8'h00 : 8'hf0, input_buf_en_reg);
        core_u.wake($random(seed) & 3, hc);
        cmp("wake_halt", 1, hc >= 5 && hc < 12);
      end
      axi_wr(`SPRC_IDX_SLEEP_CTRL, 32'h0);
    end
    core_u.comp_enabled <= 1'b0;
    core_u.conv_enabled <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("ref_power", 0, ref_power_reg);
    axi_wr(`SPRC_IDX_SLEEP_CTRL, 32'h8);
    @(posedge clk);
    por_raw <= 1'b1;
    #2;
    cmp("io_reset", 1, io_reset_reg);
    repeat (3) @(posedge clk);
    por_raw <= 1'b0;
    wait_run();
    axi_rd(`SPRC_IDX_SLEEP_CTRL, 32'h0, 2'b00);
    axi_rd(`SPRC_IDX_RESET_FLAGS, 32'h1, 2'b00);
    ext_reset_disable_fuse <= 1'b1;
    reset_pin_n <= 1'b0;
    repeat (150) @(posedge clk);
    cmp("fuse_block", 0, core_reset_reg);
    reset_pin_n <= 1'b1;
    ext_reset_disable_fuse <= 1'b0;
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (150) @(posedge clk);
    cmp("pin_reset", 1, core_reset_reg);
    reset_pin_n <= 1'b1;
    wait_run();
    wdt_reset_pulse <= 1'b1;
    @(posedge clk);
    wdt_reset_pulse <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("wdt_reset", 1, core_reset_reg);
    wait_run();
    axi_wr(`SPRC_IDX_SUPPLY_MON, 32'h0);
    supply_below <= 1'b1;
    repeat (6) @(posedge clk);
    axi_rd(`SPRC_IDX_SUPPLY_MON, 32'h20, 2'b00);
    supply_below <= 1'b0;
    repeat (6) @(posedge clk);
    axi_rd(`SPRC_IDX_SUPPLY_MON, 32'h0, 2'b00);
    axi_wr(`SPRC_IDX_SUPPLY_MON, 32'h10);
    supply_below <= 1'b1;
    repeat (30) @(posedge clk);
    cmp("supply_hold", 1, core_reset_reg);
    supply_below <= 1'b0;
    wait_run();
    test_done();
  end
endmodule // sprc_power_ctrl_test
bind sprc_power_ctrl sprc_power_checker #(.TOUT_CYC(TOUT_CYC)) chk_u (.*);
